/* core/acc_top.sv */
// conversion control, result readout and input disable logic
// Function
// - reading low result byte freezes both bytes until high byte read
// - result right adjusted when left adjust clear, left when set
// - left adjust change rearranges result view immediately
// - enable on powers converter; clearing aborts running conversion
// - start write begins conversion; free running restarts on its own
// - first conversion after enable takes 26 clocks, later ones 15
// - start bit reads one while busy; writing zero does nothing
// - auto trigger starts conversion on rising edge of selected flag
// - done flag set on completion; cleared by vector ack or write one
// - irq when done flag, irq enable and global enable all set
// - divisor codes 0..7 give 2,2,4,8,16,32,64,128
// - trigger field selects source; ignored with auto trigger off
// - switching from a clear to a set source counts as rising edge
// - selecting free running mode itself makes no trigger event
// - input disable bits force matching port input bits to zero
// - upper bits of disable 1 read zero; reserved bits written zero
// - channel select change waits until conversion completes
// - differential results two's complement, single ended unsigned
`timescale 1ns/1ps
module acc_top
   import acc_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic o_bvalid,
   output logic [1:0] o_bresp,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic o_rvalid,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   input wire logic i_rready,
   input wire logic i_global_irq_en,
   input wire logic i_irq_ack,
   input wire logic [7:0] i_trig_flags,
   input wire logic [9:0] i_sample,
   input wire logic [11:0] i_pin_raw,
   output logic [11:0] o_port_input_bit,
   output logic [11:0] o_pin_input_disable_bit,
   output logic [5:0] o_channel_active,
   output logic o_converting,
   output logic o_conv_clk_tick,
   output logic o_irq
);
   acc_state_rec_t s_r;
   acc_state_rec_t s_nxt;
   logic [7:0] div_mask;
   logic tick;
   logic trig_now;
   logic trig_edge;
   logic start_req;
   logic done_evt;
   logic wr_fire;
   logic rd_fire;
   logic [7:0] low_view;
   logic [7:0] high_view;
   logic [9:0] shown;
   logic [11:0] pin_s1_r;
   logic [11:0] pin_s2_r;
   logic [11:0] pin_s3_r;
   logic [11:0] pin_q_r;

   // ****************************************
   // prescaler and result view
   // ****************************************
   always_comb
   begin
      case (s_r.ctrl_a[2:0])
         3'h0: div_mask = 8'h01;
         3'h1: div_mask = 8'h01;
         3'h2: div_mask = 8'h03;
         3'h3: div_mask = 8'h07;
         3'h4: div_mask = 8'h0F;
         3'h5: div_mask = 8'h1F;
         3'h6: div_mask = 8'h3F;
         default: div_mask = 8'h7F;
      endcase
   end
   assign tick = ({1'b0, s_r.presc} & div_mask) == div_mask;
   assign shown = s_r.locked ? s_r.held : s_r.result;
   always_comb
   begin
      if (s_r.ctrl_b[BIT_LEFT_ADJ])
      begin
         high_view = shown[9:2];
         low_view = {shown[1:0], 6'h00};
      end
      else
      begin
         high_view = {6'h00, shown[9:8]};
         low_view = shown[7:0];
      end
   end

   // ****************************************
   // trigger selection
   // ****************************************
   always_comb
   begin
      // selected flag level, source 0 unused
      trig_now = s_r.trig_s3[s_r.ctrl_b[2:0]] & s_r.trig_s2[s_r.ctrl_b[2:0]];
      if (s_r.ctrl_b[2:0] == 3'h0)
      begin
         trig_now = 1'b0;
      end
   end
   // rising edge, none from free running select
   assign trig_edge = trig_now & ~s_r.trig_prev & s_r.ctrl_a[BIT_AUTO];

   assign wr_fire = s_r.aw_got & s_r.w_got & ~s_r.bvalid;
   assign rd_fire = i_arvalid & ~s_r.rvalid;
   assign done_evt = (s_r.state == ACC_CONV) & tick & (s_r.cyc == 5'd1)
      & s_r.ctrl_a[BIT_ENABLE];

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      s_nxt = s_r;
      start_req = 1'b0;
      s_nxt.trig_s1 = i_trig_flags;
      s_nxt.trig_s2 = s_r.trig_s1;
      s_nxt.trig_s3 = s_r.trig_s2;
      s_nxt.samp_s1 = i_sample;
      s_nxt.samp_s2 = s_r.samp_s1;
      s_nxt.samp_s3 = s_r.samp_s2;
      s_nxt.trig_prev = trig_now;
      s_nxt.presc = s_r.presc + 7'd1;
      // bus handshakes
      if (i_awvalid && !s_r.aw_got)
      begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_addr = i_awaddr;
      end
      if (i_wvalid && !s_r.w_got)
      begin
         s_nxt.w_got = 1'b1;
         s_nxt.w_data = i_wdata[7:0];
         s_nxt.w_strb0 = i_wstrb[0];
      end
      if (s_r.bvalid && i_bready)
      begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.rvalid && i_rready)
      begin
         s_nxt.rvalid = 1'b0;
      end
      // reads
      if (rd_fire)
      begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = AXI_OKAY;
         s_nxt.rdata = 32'h0000_0000;
         case (i_araddr)
            ADDR_RESULT_LOW:
            begin
               s_nxt.rdata[7:0] = low_view;
               s_nxt.locked = 1'b1;
               s_nxt.held = shown;
            end
            ADDR_RESULT_HIGH:
            begin
               s_nxt.rdata[7:0] = high_view;
               s_nxt.locked = 1'b0;
            end
            ADDR_CTRL_STATUS_A:
            begin
               s_nxt.rdata[7:0] = s_r.ctrl_a;
               s_nxt.rdata[BIT_START] = s_r.state == ACC_CONV;
            end
            ADDR_CTRL_STATUS_B: s_nxt.rdata[3:0] = s_r.ctrl_b;
            ADDR_INPUT_DIS_0: s_nxt.rdata[7:0] = s_r.dis0;
            ADDR_INPUT_DIS_1: s_nxt.rdata[3:0] = s_r.dis1;
            ADDR_CHANNEL_SEL: s_nxt.rdata[5:0] = s_r.chan;
            default: s_nxt.rresp = AXI_SLVERR;
         endcase
      end
      // writes
      if (wr_fire)
      begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = AXI_OKAY;
         if (s_r.w_strb0)
         begin
            case (s_r.aw_addr)
               ADDR_CTRL_STATUS_A:
               begin
                  s_nxt.ctrl_a = s_r.w_data;
                  s_nxt.ctrl_a[BIT_START] = 1'b0;
                  s_nxt.ctrl_a[BIT_DONE] = s_r.ctrl_a[BIT_DONE]
                     & ~s_r.w_data[BIT_DONE];
                  start_req = s_r.w_data[BIT_START] & s_r.w_data[BIT_ENABLE];
                  if (!s_r.ctrl_a[BIT_ENABLE])
                  begin
                     s_nxt.initialized = 1'b0;
                  end
               end
               ADDR_CTRL_STATUS_B:
               begin
                  s_nxt.ctrl_b = s_r.w_data[3:0] & CTRL_B_MASK[3:0];
               end
               ADDR_INPUT_DIS_0: s_nxt.dis0 = s_r.w_data;
               ADDR_INPUT_DIS_1:
               begin
                  s_nxt.dis1 = s_r.w_data[3:0] & INPUT_DIS_1_MASK[3:0];
               end
               ADDR_CHANNEL_SEL: s_nxt.chan = s_r.w_data[5:0];
               ADDR_RESULT_LOW, ADDR_RESULT_HIGH: s_nxt.bresp = AXI_OKAY;
               default: s_nxt.bresp = AXI_SLVERR;
            endcase
         end
         else if (s_r.aw_addr > ADDR_CHANNEL_SEL || s_r.aw_addr[1:0] != 2'b00)
         begin
            s_nxt.bresp = AXI_SLVERR;
         end
      end
      if (i_irq_ack)
      begin
         s_nxt.ctrl_a[BIT_DONE] = 1'b0;
      end
      case (s_r.state)
         ACC_IDLE:
         begin
            if ((start_req || trig_edge) && s_nxt.ctrl_a[BIT_ENABLE])
            begin
               s_nxt.state = ACC_CONV;
               s_nxt.presc = 7'd0;
               s_nxt.cyc = s_r.initialized ? NORMAL_CONV_CYCLES : FIRST_CONV_CYCLES;
               s_nxt.initialized = 1'b1;
               s_nxt.chan_act = s_r.chan;
            end
         end
         ACC_CONV:
         begin
            if (!s_nxt.ctrl_a[BIT_ENABLE])
            begin
               s_nxt.state = ACC_IDLE;
               s_nxt.initialized = 1'b0;
            end
            else if (done_evt)
            begin
               s_nxt.ctrl_a[BIT_DONE] = 1'b1;
               // result taken as delivered by the core
               s_nxt.result = s_r.samp_s3;
               // new channel takes effect at completion
               s_nxt.chan_act = s_r.chan;
               if (s_nxt.ctrl_a[BIT_AUTO] && s_r.ctrl_b[2:0] == 3'h0)
               begin
                  s_nxt.cyc = NORMAL_CONV_CYCLES;
                  s_nxt.presc = 7'd0;
               end
               else
               begin
                  s_nxt.state = ACC_IDLE;
               end
            end
            else if (tick)
            begin
               s_nxt.cyc = s_r.cyc - 5'd1;
            end
         end
         default: s_nxt.state = ACC_IDLE;
      endcase
      if (!s_nxt.ctrl_a[BIT_ENABLE])
      begin
         s_nxt.initialized = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // pin input buffers
   // ****************************************
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         pin_s1_r <= 12'h000;
         pin_s2_r <= 12'h000;
         pin_s3_r <= 12'h000;
         pin_q_r <= 12'h000;
      end
      else
      begin
         pin_s1_r <= i_pin_raw;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         pin_q_r <= (pin_s2_r & pin_s3_r) | (pin_q_r & (pin_s2_r | pin_s3_r));
      end
   end
   assign o_port_input_bit = pin_q_r & ~{s_r.dis1, s_r.dis0};
   assign o_pin_input_disable_bit = {s_r.dis1, s_r.dis0};

   assign o_awready = ~s_r.aw_got;
   assign o_wready = ~s_r.w_got;
   assign o_bvalid = s_r.bvalid;
   assign o_bresp = s_r.bresp;
   assign o_arready = ~s_r.rvalid;
   assign o_rvalid = s_r.rvalid;
   assign o_rdata = s_r.rdata;
   assign o_rresp = s_r.rresp;
   assign o_channel_active = s_r.chan_act;
   assign o_converting = s_r.state == ACC_CONV;
   assign o_conv_clk_tick = tick;
   assign o_irq = s_r.ctrl_a[BIT_DONE] & s_r.ctrl_a[BIT_IRQ_EN] & i_global_irq_en;

   // ****************************************
   // assertions
   // ****************************************
   sequence seq_low_read;
      rd_fire && i_araddr == ADDR_RESULT_LOW;
   endsequence
   sequence seq_no_high_read;
      !(rd_fire && i_araddr == ADDR_RESULT_HIGH);
   endsequence
   AST_LOCK_HOLDS: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      seq_low_read ##1 seq_no_high_read |=> $stable(shown))
      else $error("result changed while locked");
   AST_RIGHT_ADJ: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !s_r.ctrl_b[BIT_LEFT_ADJ] |-> high_view[7:2] == 6'h00 && low_view == shown[7:0])
      else $error("right adjust wrong");
   AST_LEFT_ADJ: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      s_r.ctrl_b[BIT_LEFT_ADJ] |-> high_view == shown[9:2] && low_view[5:0] == 6'h00)
      else $error("left adjust wrong");
   AST_ABORT: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !s_nxt.ctrl_a[BIT_ENABLE] |=> s_r.state == ACC_IDLE)
      else $error("conversion survived disable");
   AST_START: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      s_r.state == ACC_IDLE && start_req |=> s_r.state == ACC_CONV)
      else $error("start write ignored");
   AST_FIRST_LEN: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      s_r.state == ACC_IDLE && s_nxt.state == ACC_CONV && !s_r.initialized
      |=> s_r.cyc == FIRST_CONV_CYCLES)
      else $error("first conversion length wrong");
   AST_DONE_SET: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      done_evt |=> s_r.ctrl_a[BIT_DONE])
      else $error("done flag not set");
   AST_IRQ: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_irq == (s_r.ctrl_a[BIT_DONE] && s_r.ctrl_a[BIT_IRQ_EN] && i_global_irq_en))
      else $error("irq gating wrong");
   AST_DIS_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (o_port_input_bit & {s_r.dis1, s_r.dis0}) == 12'h000)
      else $error("disabled input not zero");
   AST_CHAN_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      s_r.state == ACC_CONV && !done_evt && s_nxt.state == ACC_CONV
      |=> $stable(o_channel_active))
      else $error("channel changed mid conversion");
endmodule

/* core/acc_pkg.sv */
// shared constants and types for the conversion control block
package acc_pkg;
   // ****************************************
   // register byte addresses
   // ****************************************
   localparam logic [7:0] ADDR_RESULT_LOW = 8'h00;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'h04;
   localparam logic [7:0] ADDR_CTRL_STATUS_A = 8'h08;
   localparam logic [7:0] ADDR_CTRL_STATUS_B = 8'h0C;
   localparam logic [7:0] ADDR_INPUT_DIS_0 = 8'h10;
   localparam logic [7:0] ADDR_INPUT_DIS_1 = 8'h14;
   localparam logic [7:0] ADDR_CHANNEL_SEL = 8'h18;
   // ****************************************
   // field positions
   // ****************************************
   localparam int BIT_ENABLE = 7;
   localparam int BIT_START = 6;
   localparam int BIT_AUTO = 5;
   localparam int BIT_DONE = 4;
   localparam int BIT_IRQ_EN = 3;
   localparam int BIT_LEFT_ADJ = 3;
   localparam logic [7:0] INPUT_DIS_1_MASK = 8'h0F;
   localparam logic [7:0] CTRL_B_MASK = 8'h0F;
   // ****************************************
   // reset values and timing
   // ****************************************
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [4:0] FIRST_CONV_CYCLES = 5'd26;
   localparam logic [4:0] NORMAL_CONV_CYCLES = 5'd15;
   localparam logic [1:0] AXI_OKAY = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;
   typedef enum logic [1:0]
   {
      ACC_IDLE = 2'b00,
      ACC_CONV = 2'b01
   } acc_state_t;
   // ****************************************
   // state record
   // ****************************************
   typedef struct packed
   {
      acc_state_t state;
      logic [7:0] ctrl_a;
      logic [3:0] ctrl_b;
      logic [7:0] dis0;
      logic [3:0] dis1;
      logic [5:0] chan;
      logic [5:0] chan_act;
      logic [9:0] result;
      logic locked;
      logic [9:0] held;
      logic initialized;
      logic [6:0] presc;
      logic [4:0] cyc;
      logic trig_prev;
      logic [7:0] trig_s1;
      logic [7:0] trig_s2;
      logic [7:0] trig_s3;
      logic [9:0] samp_s1;
      logic [9:0] samp_s2;
      logic [9:0] samp_s3;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [7:0] w_data;
      logic w_strb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } acc_state_rec_t;
endpackage

/* tb/acc_partner_model.sv */
// converter core and trigger source model
`timescale 1ns/1ps
module acc_partner_model
   import acc_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_converting,
   input wire logic [5:0] i_channel_active,
   input wire logic [7:0] i_flag_req,
   output logic [9:0] o_sample,
   output logic [7:0] o_trig_flags
);
   logic [9:0] last_r = 10'h000;
   always_ff @(posedge i_ref_clk)
   begin
      if (i_converting)
      begin
         o_sample <= {i_channel_active, 4'h9};
         last_r <= {i_channel_active, 4'h9};
      end
      else
      begin
         o_sample <= ~last_r;
      end
      o_trig_flags <= i_flag_req;
   end
endmodule

/* tb/tb_analog_conversion_control.sv */
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module tb_analog_conversion_control
   import acc_pkg::*;
   ;
   logic i_ref_clk, i_sys_rst, i_awvalid, i_wvalid, i_bready, i_arvalid;
   logic i_rready, i_global_irq_en, i_irq_ack, prev_conv;
   logic [7:0] i_awaddr, i_araddr, i_trig_flags, flag_req;
   logic [31:0] i_wdata, o_rdata, rd;
   logic [3:0] i_wstrb;
   logic [9:0] i_sample;
   logic [11:0] i_pin_raw, o_port_input_bit, o_pin_input_disable_bit;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0] o_bresp, o_rresp, rsp;
   logic [5:0] o_channel_active;
   logic o_converting, o_conv_clk_tick, o_irq;
   int fails = 0, cmp_count = 0, cycles = 0, period = 0, tcnt = 0;
   int nticks = 0, last_len = 0, nconv = 0, n0;
   logic [7:0] regs [6] = '{ADDR_RESULT_LOW, ADDR_RESULT_HIGH,
      ADDR_CTRL_STATUS_A, ADDR_CTRL_STATUS_B, ADDR_INPUT_DIS_0,
      ADDR_INPUT_DIS_1};

   acc_top u_acc_top (.i_ref_clk, .i_sys_rst, .i_awaddr, .i_awvalid,
      .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bvalid,
      .o_bresp, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rvalid,
      .o_rdata, .o_rresp, .i_rready, .i_global_irq_en, .i_irq_ack,
      .i_trig_flags, .i_sample, .i_pin_raw, .o_port_input_bit,
      .o_pin_input_disable_bit, .o_channel_active, .o_converting,
      .o_conv_clk_tick, .o_irq);

   acc_partner_model u_acc_partner_model (.i_ref_clk,
      .i_converting(o_converting), .i_channel_active(o_channel_active),
      .i_flag_req(flag_req), .o_sample(i_sample),
      .o_trig_flags(i_trig_flags));

   // ****************************************
   // clock, monitor and timeout
   // ****************************************
   initial
   begin
      i_ref_clk = 1'b0;
      forever #20 i_ref_clk = ~i_ref_clk;
   end

   always @(posedge i_ref_clk)
   begin
      cycles <= cycles + 1;
      tcnt <= o_conv_clk_tick ? 0 : tcnt + 1;
      if (o_conv_clk_tick)
         period <= tcnt + 1;
      nticks <= !o_converting ? 0 : nticks + int'(o_conv_clk_tick);
      if (prev_conv && !o_converting)
         last_len <= nticks;
      if (!prev_conv && o_converting)
         nconv <= nconv + 1;
      prev_conv <= o_converting;
      if (cycles > 60000)
      begin
         fails++;
         final_report();
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic final_report();
      if (fails == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw_p;
      logic w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      @(posedge i_ref_clk);
      i_awaddr <= a;
      i_wdata <= {24'h000000, d};
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      while (aw_p || w_p)
      begin
         @(posedge i_ref_clk);
         if (aw_p && o_awready)
         begin
            aw_p = 1'b0;
            i_awvalid <= 1'b0;
         end
         if (w_p && o_wready)
         begin
            w_p = 1'b0;
            i_wvalid <= 1'b0;
         end
      end
      while (o_bvalid !== 1'b1)
         @(posedge i_ref_clk);
      i_bready <= 1'b0;
   endtask

   task automatic rd8(input logic [7:0] a);
      @(posedge i_ref_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      @(posedge i_ref_clk);
      while (o_arready !== 1'b1)
         @(posedge i_ref_clk);
      i_arvalid <= 1'b0;
      @(posedge i_ref_clk);
      while (o_rvalid !== 1'b1)
         @(posedge i_ref_clk);
      rd = o_rdata;
      rsp = o_rresp;
      i_rready <= 1'b0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      rd8(a);
      chk({24'h000000, rd[7:0]}, {24'h000000, e});
   endtask

   task automatic wait_done();
      rd = 32'h00000000;
      repeat (3000)
      begin
         if (rd[BIT_DONE] !== 1'b1)
            rd8(ADDR_CTRL_STATUS_A);
      end
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
      {i_global_irq_en, i_irq_ack, i_awaddr, i_araddr} = 18'h00000;
      i_sys_rst = 1'b1;
      i_wdata = 32'h00000000;
      i_wstrb = 4'hF;
      flag_req = 8'h00;
      i_pin_raw = 12'hFFF;
      repeat (4) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      foreach (regs[i])
         rc(regs[i], 8'h00);
      rd8(8'h1C);
      chk({30'h00000000, rsp}, {30'h00000000, AXI_SLVERR});
      wr(ADDR_CHANNEL_SEL, 8'h05);
      i_global_irq_en <= 1'b1;
      wr(ADDR_CTRL_STATUS_A, 8'hC9);
      rd8(ADDR_CTRL_STATUS_A);
      chk(32'(rd[BIT_START]), 32'h1);
      wait_done();
      chk(32'(last_len), 32'h1A);
      chk(32'(o_irq), 32'h1);
      i_global_irq_en <= 1'b0;
      @(posedge i_ref_clk);
      chk(32'(o_irq), 32'h0);
      rc(ADDR_RESULT_HIGH, 8'h00);
      rc(ADDR_RESULT_LOW, 8'h59);
      wr(ADDR_CTRL_STATUS_B, 8'h08);
      rc(ADDR_RESULT_LOW, 8'h40);
      rc(ADDR_RESULT_HIGH, 8'h16);
      wr(ADDR_CTRL_STATUS_B, 8'h00);
      i_irq_ack <= 1'b1;
      @(posedge i_ref_clk);
      i_irq_ack <= 1'b0;
      rd8(ADDR_CTRL_STATUS_A);
      chk(32'(rd[BIT_DONE]), 32'h0);
      rc(ADDR_RESULT_LOW, 8'h59);
      wr(ADDR_CHANNEL_SEL, 8'h2A);
      wr(ADDR_CTRL_STATUS_A, 8'hC8);
      wr(ADDR_CHANNEL_SEL, 8'h11);
      chk(32'(o_channel_active), 32'h2A);
      wait_done();
      chk(32'(last_len), 32'hF);
      rc(ADDR_RESULT_HIGH, 8'h00);
      rc(ADDR_RESULT_LOW, 8'hA9);
      rc(ADDR_RESULT_HIGH, 8'h02);
      wr(ADDR_CTRL_STATUS_A, 8'h98);
      rd8(ADDR_CTRL_STATUS_A);
      chk({30'h00000000, rd[BIT_START], rd[BIT_DONE]}, 32'h0);
      wr(ADDR_CTRL_STATUS_A, 8'hC8);
      wr(ADDR_CTRL_STATUS_A, 8'h08);
      chk(32'(o_converting), 32'h0);
      repeat (60) @(posedge i_ref_clk);
      rd8(ADDR_CTRL_STATUS_A);
      chk(32'(rd[BIT_DONE]), 32'h0);
      for (int c = 0; c < 8; c++)
      begin
         wr(ADDR_CTRL_STATUS_A, 8'hC0 | 8'(c));
         wait_done();
         chk(32'(period), (c < 2) ? 32'h2 : 32'h1 << c);
         wr(ADDR_CTRL_STATUS_A, 8'h10);
      end
      n0 = nconv;
      wr(ADDR_CTRL_STATUS_A, 8'h81);
      wr(ADDR_CTRL_STATUS_B, 8'h01);
      flag_req <= 8'h02;
      repeat (40) @(posedge i_ref_clk);
      flag_req <= 8'h00;
      chk(32'(nconv - n0), 32'h0);
      repeat (6) @(posedge i_ref_clk);
      for (int k = 1; k < 8; k++)
      begin
         wr(ADDR_CTRL_STATUS_A, 8'hB1);
         flag_req <= 8'h00;
         repeat (6) @(posedge i_ref_clk);
         n0 = nconv;
         if (k[0])
         begin
            wr(ADDR_CTRL_STATUS_B, 8'(k));
            flag_req <= 8'h01 << k;
         end
         else
         begin
            flag_req <= 8'h01 << k;
            repeat (6) @(posedge i_ref_clk);
            wr(ADDR_CTRL_STATUS_B, 8'(k));
         end
         wait_done();
         chk(32'(nconv - n0), 32'h1);
      end
      flag_req <= 8'h00;
      n0 = nconv;
      wr(ADDR_CTRL_STATUS_B, 8'h00);
      repeat (40) @(posedge i_ref_clk);
      chk(32'(nconv - n0), 32'h0);
      wr(ADDR_CTRL_STATUS_A, 8'hE1);
      repeat (200) @(posedge i_ref_clk);
      chk(32'(nticks >= 86), 32'h1);
      wr(ADDR_CTRL_STATUS_A, 8'h10);
      wr(ADDR_INPUT_DIS_0, 8'hA5);
      wr(ADDR_INPUT_DIS_1, 8'hFF);
      rc(ADDR_INPUT_DIS_1, 8'h0F);
      rc(ADDR_INPUT_DIS_0, 8'hA5);
      repeat (8) @(posedge i_ref_clk);
      chk(32'(o_port_input_bit), 32'h05A);
      chk(32'(o_pin_input_disable_bit), 32'hFA5);
      final_report();
   end
endmodule
